// [src/eeprom_config_loader.sv]
// Summary of operation
// RULE1: Interface byte bit 7 low gives two-wire high speed, high gives high speed plus.
// RULE2: Interface byte bit 4 low takes the bus address from straps, high from the store.
// RULE3: Interface byte bit 3 low enables boundary scan, high disables it.
// RULE4: Low three bits pick serial, two-wire, SPI or low two-wire; top bit set defers to pins.
// RULE5: The secondary bus address always comes from the store.
// RULE6: Each protocol entry copies 16 transmit bytes and 8 receive bytes.
// RULE7: The default copy writes only read/write or dynamic register bits.
// RULE8: The default copy source pointer is taken from configuration; the code copies only after reset, so always from the reset value 40h.
// RULE9: Stored defaults become the configuration in force after startup.
// RULE10: A protocol load command copies a chosen protocol set on request.
// RULE11: The transmit CRC seed is taken from stored configuration.
// RULE12: At startup the register reset image is copied into the registers.
// RULE13: Protocol load copies one set from the read-only protocol area.
// RULE14: The interface byte is read from store address 21h.
// RULE15: Host and command processing stay inactive until startup completes, then done rises.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_loader_cfg.svh"
module eeprom_config_loader #(
    parameter int ADDR_W = 13,
    parameter int PROT_COUNT = 32
) (
    input wire logic mclk,
    input wire logic reset,
    output logic [ADDR_W-1:0] mem_addr,
    output logic mem_rd,
    input wire logic [7:0] mem_rdata,
    output logic reg_we,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic [7:0] reg_wmask,
    input wire logic [7:0] reg_rw_mask,
    input wire logic [1:0] strap_pins,
    input wire logic [2:0] host_pins,
    output cfg_loader_pkg::host_sel_type host_select,
    output logic host_enable,
    output logic twowire_speed_select,
    output logic [6:0] twowire_addr,
    output logic [6:0] sam_addr,
    output logic bscan_enable,
    output logic [15:0] tx_crc_seed,
    output logic load_done,
    input wire logic [3:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    output logic [7:0] cmd_rdata
);
    import cfg_loader_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [1:0] strap_s1_q, strap_s2_q, strap_s3_q, strap_q;
    logic [1:0] strap_d;
    logic [2:0] host_s1_q, host_s2_q, host_s3_q, host_q;
    logic [2:0] host_d;
    always_comb begin
        strap_d = strap_q;
        host_d = host_q;
        if (strap_s2_q == strap_s3_q) begin
            strap_d = strap_s3_q;
        end
        if (host_s2_q == host_s3_q) begin
            host_d = host_s3_q;
        end
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            strap_s1_q <= 2'h0;
            strap_s2_q <= 2'h0;
            strap_s3_q <= 2'h0;
            strap_q <= 2'h0;
            host_s1_q <= 3'h0;
            host_s2_q <= 3'h0;
            host_s3_q <= 3'h0;
            host_q <= 3'h0;
        end else begin
            strap_s1_q <= strap_pins;
            strap_s2_q <= strap_s1_q;
            strap_s3_q <= strap_s2_q;
            strap_q <= strap_d;
            host_s1_q <= host_pins;
            host_s2_q <= host_s1_q;
            host_s3_q <= host_s2_q;
            host_q <= host_d;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    loader_state_type state_q, state_d;
    logic [7:0] cnt_q, cnt_d;
    logic phase_q, phase_d;
    logic [7:0] ifb_q, ifb_d;
    logic [6:0] twa_q, twa_d;
    logic [6:0] sam_q, sam_d;
    logic [15:0] seed_q, seed_d;
    logic [ADDR_W-1:0] base_q, base_d;
    logic [4:0] prot_q, prot_d;
    logic busy_q, busy_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic rd_q, rd_d;
    logic we_q, we_d;
    logic [6:0] waddr_q, waddr_d;
    logic [7:0] wdata_q, wdata_d;
    logic [7:0] wmask_q, wmask_d;
    logic [ADDR_W-1:0] ptx_base;
    logic [ADDR_W-1:0] cfg_addr;

    assign ptx_base = ADDR_W'(`ADDR_PROTOCOL_AREA) + ADDR_W'({prot_q, 4'h0});
    always_comb begin
        case (cnt_q[2:0])
            3'h0: cfg_addr = ADDR_W'(`ADDR_IFACE_CFG);
            3'h1: cfg_addr = ADDR_W'(`ADDR_TWOWIRE_ADDR);
            3'h2: cfg_addr = ADDR_W'(`ADDR_SAM_ADDR);
            3'h3: cfg_addr = ADDR_W'(`ADDR_TX_CRC_SEED);
            default: cfg_addr = ADDR_W'(`ADDR_TX_CRC_SEED) + ADDR_W'(1);
        endcase
    end

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        phase_d = phase_q;
        ifb_d = ifb_q;
        twa_d = twa_q;
        sam_d = sam_q;
        seed_d = seed_q;
        base_d = base_q;
        prot_d = prot_q;
        busy_d = busy_q;
        addr_d = addr_q;
        rd_d = 1'b0;
        we_d = 1'b0;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        wmask_d = wmask_q;
        case (state_q)
            ST_IDLE: begin
                state_d = ST_IFB;
                cnt_d = 8'h00;
                phase_d = 1'b0;
            end
            ST_IFB: begin
                if (!phase_q) begin
                    addr_d = cfg_addr; // RULE14
                    rd_d = 1'b1;
                    phase_d = 1'b1;
                end else if (!rd_q) begin
                    phase_d = 1'b0;
                    cnt_d = cnt_q + 8'h01;
                    case (cnt_q[2:0])
                        3'h0: ifb_d = mem_rdata;
                        3'h1: twa_d = mem_rdata[6:0];
                        3'h2: sam_d = mem_rdata[6:0]; // RULE5
                        3'h3: seed_d[15:8] = mem_rdata; // RULE11
                        default: begin
                            seed_d[7:0] = mem_rdata; // RULE11
                            state_d = ST_COPY;
                            cnt_d = 8'h00;
                        end
                    endcase
                end
            end
            ST_COPY, ST_PTX, ST_PRX: begin
                if (!phase_q) begin
                    if (state_q == ST_COPY) begin
                        addr_d = base_q + ADDR_W'(cnt_q); // RULE8 RULE12
                    end else if (state_q == ST_PTX) begin
                        addr_d = ptx_base + ADDR_W'(cnt_q); // RULE13
                    end else begin
                        addr_d = ptx_base + ADDR_W'(`PROT_RX_OFS) + ADDR_W'(cnt_q);
                    end
                    rd_d = 1'b1;
                    phase_d = 1'b1;
                end else if (!rd_q) begin
                    phase_d = 1'b0;
                    we_d = 1'b1;
                    wdata_d = mem_rdata; // RULE9
                    wmask_d = reg_rw_mask; // RULE7
                    cnt_d = cnt_q + 8'h01;
                    if (state_q == ST_COPY) begin
                        waddr_d = 7'(cnt_q);
                        if (cnt_q == `RESET_IMAGE_LEN - 8'h01) begin
                            state_d = ST_RUN;
                        end
                    end else if (state_q == ST_PTX) begin
                        waddr_d = `REG_PROT_TX_BASE + 7'(cnt_q);
                        if (cnt_q == `PROT_TX_LEN - 8'h01) begin // RULE6
                            state_d = ST_PRX;
                            cnt_d = 8'h00;
                        end
                    end else begin
                        waddr_d = `REG_PROT_RX_BASE + 7'(cnt_q);
                        if (cnt_q == `PROT_RX_LEN - 8'h01) begin // RULE6
                            state_d = ST_RUN;
                            busy_d = 1'b0;
                        end
                    end
                end
            end
            ST_RUN: begin
                if (cmd_wr && cmd_addr == `CMD_ADDR_PROT) begin
                    prot_d = 5'(cmd_wdata); // RULE10
                end
                if (cmd_wr && cmd_addr == `CMD_ADDR_BASE) begin
                    base_d = ADDR_W'({cmd_wdata, 6'h00}); // RULE8
                end
                if (cmd_wr && cmd_addr == `CMD_ADDR_CTRL && cmd_wdata[0]) begin
                    state_d = ST_PTX; // RULE10 RULE13
                    cnt_d = 8'h00;
                    phase_d = 1'b0;
                    busy_d = 1'b1;
                    if (cmd_wdata[1]) begin
                        prot_d = 5'(cmd_wdata[7:2]);
                    end
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
            cnt_q <= 8'h00;
            phase_q <= 1'b0;
            ifb_q <= `IFACE_CFG_RESET;
            twa_q <= 7'h00;
            sam_q <= 7'h00;
            seed_q <= 16'h0000;
            base_q <= ADDR_W'(`ADDR_RESET_IMAGE);
            prot_q <= 5'h00;
            busy_q <= 1'b0;
            addr_q <= '0;
            rd_q <= 1'b0;
            we_q <= 1'b0;
            waddr_q <= 7'h00;
            wdata_q <= 8'h00;
            wmask_q <= 8'h00;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            phase_q <= phase_d;
            ifb_q <= ifb_d;
            twa_q <= twa_d;
            sam_q <= sam_d;
            seed_q <= seed_d;
            base_q <= base_d;
            prot_q <= prot_d;
            busy_q <= busy_d;
            addr_q <= addr_d;
            rd_q <= rd_d;
            we_q <= we_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            wmask_q <= wmask_d;
        end
    end

    // ****************************************
    // Decoded outputs
    // ****************************************
    logic done;
    assign done = (state_q == ST_RUN) || (state_q == ST_PTX) || (state_q == ST_PRX);
    assign load_done = done; // RULE15
    assign host_enable = done; // RULE15
    assign mem_addr = addr_q;
    assign mem_rd = rd_q;
    assign reg_we = we_q;
    assign reg_addr = waddr_q;
    assign reg_wdata = wdata_q;
    assign reg_wmask = wmask_q;
    assign twowire_speed_select = ifb_q[`IFB_SPEED]; // RULE1
    assign bscan_enable = ~ifb_q[`IFB_BSCAN]; // RULE3
    assign twowire_addr = ifb_q[`IFB_ADDR_SRC] ? twa_q
                        : {`STRAP_ADDR_PREFIX, strap_q}; // RULE2
    assign sam_addr = sam_q; // RULE5
    assign tx_crc_seed = seed_q; // RULE11
    always_comb begin
        if (ifb_q[`IFB_HOST_MSB]) begin
            host_select = host_sel_type'({1'b0, host_q[1:0]}); // RULE4
            if (host_q[2]) begin
                host_select = HOST_PINS;
            end
        end else begin
            host_select = host_sel_type'({1'b0, ifb_q[1:0]}); // RULE4
        end
    end

    // ****************************************
    // Command port readback
    // ****************************************
    logic [7:0] rdata_q, rdata_d;
    always_comb begin
        rdata_d = 8'h00;
        if (cmd_rd && done) begin // RULE15
            if (cmd_addr == `CMD_ADDR_STATUS) begin
                rdata_d = {6'h00, busy_q, done};
            end else if (cmd_addr == `CMD_ADDR_PROT) begin
                rdata_d = {3'h0, prot_q};
            end else if (cmd_addr == `CMD_ADDR_IFACE) begin
                rdata_d = ifb_q;
            end else if (cmd_addr == `CMD_ADDR_TWA) begin
                rdata_d = {1'b0, twowire_addr};
            end else if (cmd_addr == `CMD_ADDR_SAM) begin
                rdata_d = {1'b0, sam_q};
            end else if (cmd_addr == `CMD_ADDR_SEED) begin
                rdata_d = seed_q[7:0];
            end else if (cmd_addr == `CMD_ADDR_BASE) begin
                rdata_d = 8'(base_q[ADDR_W-1:6]);
            end
        end
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end
    assign cmd_rdata = rdata_q;
endmodule : eeprom_config_loader
`default_nettype wire

// [src/cfg_loader_cfg.svh]
`ifndef CFG_LOADER_CFG_SVH
`define CFG_LOADER_CFG_SVH
// ****************************************
// Store layout
// ****************************************
`define ADDR_TWOWIRE_ADDR 13'h0020
`define ADDR_IFACE_CFG 13'h0021
`define ADDR_SAM_ADDR 13'h0022
`define ADDR_PROT_RX_DEF 13'h0023
`define ADDR_PROT_TX_DEF 13'h0024
`define ADDR_TX_CRC_SEED 13'h0026
`define ADDR_RESET_IMAGE 13'h0040
`define RESET_IMAGE_LEN 8'h80
`define ADDR_PROTOCOL_AREA 13'h1C00
`define PROT_TX_LEN 8'h10
`define PROT_RX_LEN 8'h08
`define PROT_RX_OFS 13'h0200
`define REG_PROT_TX_BASE 7'h28
`define REG_PROT_RX_BASE 7'h58
// ****************************************
// Interface byte fields
// ****************************************
`define IFB_SPEED 7
`define IFB_ADDR_SRC 4
`define IFB_BSCAN 3
`define IFB_HOST_MSB 2
`define IFACE_CFG_RESET 8'h80
`define STRAP_ADDR_PREFIX 5'h15
// ****************************************
// Command port
// ****************************************
`define CMD_ADDR_CTRL 4'h0
`define CMD_ADDR_PROT 4'h1
`define CMD_ADDR_STATUS 4'h2
`define CMD_ADDR_IFACE 4'h3
`define CMD_ADDR_TWA 4'h4
`define CMD_ADDR_SAM 4'h5
`define CMD_ADDR_SEED 4'h6
`define CMD_ADDR_BASE 4'h7
`endif

// [src/cfg_loader_pkg.sv]
package cfg_loader_pkg;
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_IFB   = 6'b000010,
        ST_COPY  = 6'b000100,
        ST_RUN   = 6'b001000,
        ST_PTX   = 6'b010000,
        ST_PRX   = 6'b100000
    } loader_state_type;
    typedef enum logic [2:0] {
        HOST_SERIAL = 3'b000,
        HOST_TWOWIRE = 3'b001,
        HOST_SPI = 3'b010,
        HOST_TWOWIRE_LOW = 3'b011,
        HOST_PINS = 3'b100
    } host_sel_type;
endpackage : cfg_loader_pkg

// [bench/cfg_loader_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module cfg_loader_monitor
    import cfg_loader_pkg::*;
#(
    parameter int ADDR_W = 13
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic mem_rd,
    input wire logic [7:0] mem_rdata,
    input wire logic reg_we,
    input wire logic [7:0] reg_wmask,
    input wire logic [7:0] reg_rw_mask,
    input wire cfg_loader_pkg::host_sel_type host_select,
    input wire logic host_enable,
    input wire logic twowire_speed_select,
    input wire logic [6:0] twowire_addr,
    input wire logic [6:0] sam_addr,
    input wire logic bscan_enable,
    input wire logic [15:0] tx_crc_seed,
    input wire logic load_done
);
    // *****
    // Captured store bytes
    // *****
    logic rd_q, rd_d;
    logic [ADDR_W-1:0] pa_q, pa_d;
    logic [7:0] ifb_q, ifb_d, shi_q, shi_d;
    always_comb begin
        rd_d = mem_rd;
        pa_d = mem_rd ? mem_addr : pa_q;
        ifb_d = (rd_q && pa_q == 13'h0021) ? mem_rdata : ifb_q;
        shi_d = (rd_q && pa_q == 13'h0026) ? mem_rdata : shi_q;
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rd_q <= 1'b0;
            pa_q <= '0;
            ifb_q <= 8'h00;
            shi_q <= 8'h00;
        end else begin
            rd_q <= rd_d;
            pa_q <= pa_d;
            ifb_q <= ifb_d;
            shi_q <= shi_d;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    sequence s_fetch;
        mem_rd ##1 !mem_rd ##1 !mem_rd;
    endsequence
    a_fetch_gap: assert property (mem_rd |-> s_fetch)
        else $error("store reads too close");
    a_host_gate: assert property (!load_done |-> !host_enable)
        else $error("host enabled early");
    a_done_hold: assert property (load_done |=> load_done && host_enable)
        else $error("done dropped");
    a_mask_keep: assert property (reg_we |-> reg_wmask == $past(reg_rw_mask))
        else $error("write mask wrong");
    a_speed_map: assert property (load_done |-> twowire_speed_select == ifb_q[7])
        else $error("speed select wrong");
    a_addr_src: assert property (load_done && !ifb_q[4] |-> twowire_addr[6:2] == 5'h15)
        else $error("strap address wrong");
    a_bscan_map: assert property (load_done |-> bscan_enable == !ifb_q[3])
        else $error("scan enable wrong");
    a_host_map: assert property (load_done && !ifb_q[2] |-> host_select == ifb_q[2:0])
        else $error("host select wrong");
    a_sam_keep: assert property (load_done |=> $stable(sam_addr))
        else $error("secondary address moved");
    a_seed_high: assert property (load_done |-> tx_crc_seed[15:8] == shi_q)
        else $error("seed high byte wrong");
endmodule : cfg_loader_monitor
bind eeprom_config_loader cfg_loader_monitor #(.ADDR_W(ADDR_W)) mon_u (
    .mclk, .reset, .mem_addr, .mem_rd, .mem_rdata, .reg_we, .reg_wmask, .reg_rw_mask,
    .host_select, .host_enable, .twowire_speed_select, .twowire_addr, .sam_addr,
    .bscan_enable, .tx_crc_seed, .load_done
);
`default_nettype wire

// [bench/cfg_store_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cfg_store_model (
    input wire logic mclk,
    input wire logic [12:0] mem_addr,
    input wire logic mem_rd,
    output var logic [7:0] mem_rdata
);
    logic [7:0] mem [0:8191];
    initial begin
        mem_rdata = 8'h00;
        for (int i = 0; i < 8192; i++) begin
            mem[i] = 8'(i * 7 + (i >> 8));
        end
    end
    // Data valid one cycle after the strobe, scrambled otherwise
    always @(posedge mclk) begin
        mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
    end
endmodule : cfg_store_model
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cfg_loader_pkg::*;
    logic mclk = 1'b0, reset = 1'b1, cmd_wr = 1'b0, cmd_rd = 1'b0;
    logic mem_rd, reg_we, host_enable, twowire_speed_select, bscan_enable, load_done;
    logic [12:0] mem_addr;
    logic [7:0] mem_rdata, reg_wdata, reg_wmask, cmd_rdata, cmd_wdata = 8'h00;
    logic [7:0] reg_rw_mask = 8'hF0;
    logic [6:0] reg_addr, twowire_addr, sam_addr;
    logic [1:0] strap_pins = 2'h0;
    logic [2:0] host_pins = 3'h0;
    logic [3:0] cmd_addr = 4'h0;
    logic [15:0] tx_crc_seed;
    host_sel_type host_select;
    logic [6:0] la [0:255];
    logic [7:0] ld [0:255];
    logic [7:0] lm [0:255];
    logic [7:0] ifbs [6] = '{8'h10, 8'h89, 8'h02, 8'h9B, 8'h0C, 8'h8E};
    int errors = 0, checks_done = 0, n = 0, cyc = 0;
    eeprom_config_loader dut_u (
        .mclk, .reset, .mem_addr, .mem_rd, .mem_rdata, .reg_we, .reg_addr, .reg_wdata,
        .reg_wmask, .reg_rw_mask, .strap_pins, .host_pins, .host_select, .host_enable,
        .twowire_speed_select, .twowire_addr, .sam_addr, .bscan_enable, .tx_crc_seed,
        .load_done, .cmd_addr, .cmd_wdata, .cmd_wr, .cmd_rd, .cmd_rdata
    );
    cfg_store_model store_u (.mclk, .mem_addr, .mem_rd, .mem_rdata);
    // *****
    // Clock, write log, timeout
    // *****
    initial begin
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (reg_we === 1'b1 && n < 256) begin
            la[n] = reg_addr;
            ld[n] = reg_wdata;
            lm[n] = reg_wmask;
            n = n + 1;
        end
        if (cyc == 20000) begin
            errors = errors + 1;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic cmd_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        @(posedge mclk);
        cmd_wr <= 1'b0;
    endtask : cmd_write
    task automatic cmd_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        cmd_addr <= a;
        cmd_rd <= 1'b1;
        @(posedge mclk);
        cmd_rd <= 1'b0;
        #1 d = cmd_rdata;
    endtask : cmd_read
    // *****
    // Scenarios
    // *****
    task automatic t_startup(input int k, input logic [7:0] ifb);
        logic [7:0] d;
        logic [6:0] ea;
        int w;
        @(posedge mclk);
        reset <= 1'b1;
        reg_rw_mask <= 8'hF0 ^ 8'(k);
        strap_pins <= 2'(k);
        host_pins <= k[0] ? 3'h5 : 3'h2;
        store_u.mem[13'h0021] = ifb;
        for (w = 0; w < 128; w++) store_u.mem[13'h0040 + w] = 8'(w * 5 + k);
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        n = 0;
        cmd_read(4'h3, d);
        chk(d, 16'h0);
        chk(host_enable, 16'h0);
        for (w = 0; w < 1000 && load_done !== 1'b1; w++) @(posedge mclk);
        #1 chk(16'(n), 16'h80);
        for (w = 0; w < 128; w++) begin
            chk({la[w], ld[w]}, {7'(w), store_u.mem[13'h0040 + w]});
            chk(lm[w], reg_rw_mask);
        end
        chk(twowire_speed_select, ifb[7]);
        ea = ifb[4] ? store_u.mem[13'h0020][6:0] : {5'h15, strap_pins};
        chk(twowire_addr, ea);
        chk(bscan_enable, !ifb[3]);
        chk(host_select, ifb[2] ? (host_pins[2] ? 3'h4 : {1'b0, host_pins[1:0]}) : ifb[2:0]);
        chk(sam_addr, store_u.mem[13'h0022][6:0]);
        chk(tx_crc_seed, {store_u.mem[13'h0026], store_u.mem[13'h0027]});
        cmd_read(4'h3, d);
        chk(d, ifb);
        cmd_read(4'h4, d);
        chk(d, {9'h000, ea});
        cmd_read(4'h5, d);
        chk(d, {9'h000, store_u.mem[13'h0022][6:0]});
        cmd_read(4'h6, d);
        chk(d, {8'h00, store_u.mem[13'h0027]});
    endtask : t_startup
    task automatic t_protocol();
        logic [7:0] d;
        logic [6:0] ea;
        int w;
        n = 0;
        cmd_write(4'h1, 8'h1F);
        cmd_write(4'h0, 8'h01);
        cmd_read(4'h2, d);
        chk(d, 16'h3);
        cmd_write(4'h1, 8'h00);
        for (w = 0; w < 200 && d[1] !== 1'b0; w++) cmd_read(4'h2, d);
        chk(d, 16'h1);
        chk(16'(n), 16'h18);
        for (w = 0; w < 24; w++) begin
            ea = (w < 16) ? 7'h28 + 7'(w) : 7'h48 + 7'(w);
            d = (w < 16) ? store_u.mem[13'h1DF0 + w] : store_u.mem[13'h1FE0 + w];
            chk({la[w], ld[w]}, {ea, d});
        end
        cmd_read(4'h1, d);
        chk(d, 16'h1F);
        cmd_write(4'h7, 8'h03);
        cmd_read(4'h7, d);
        chk(d, 16'h3);
        cmd_read(4'hF, d);
        chk(d, 16'h0);
        n = 0;
        cmd_write(4'h0, 8'h0B);
        d = 8'h02;
        for (w = 0; w < 200 && d[1] !== 1'b0; w++) cmd_read(4'h2, d);
        chk(16'(n), 16'h18);
        chk({la[0], ld[0]}, {7'h28, store_u.mem[13'h1C20]});
        chk({la[16], ld[16]}, {7'h58, store_u.mem[13'h1E20]});
        cmd_read(4'h1, d);
        chk(d, 16'h2);
    endtask : t_protocol
    initial begin
        for (int k = 0; k < 6; k++) t_startup(k, ifbs[k]);
        t_protocol();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
